// >>> common/mbchk_pkg.sv
// Package of constants for the request checker
package mbchk_pkg;
  // ************************************************************
  // Function and exception codes
  // ************************************************************
  localparam logic [7:0] FC_READ        = 8'h03;
  localparam logic [7:0] FC_LOOPBACK    = 8'h08;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EX_NONE        = 8'h00;
  localparam logic [7:0] EX_FUNC        = 8'h01;
  localparam logic [7:0] EX_REG         = 8'h02;
  localparam logic [7:0] EX_QTY         = 8'h03;
  localparam logic [7:0] EX_DATA        = 8'h21;
  localparam logic [7:0] EX_WMODE       = 8'h22;
  localparam logic [7:0] EX_UV          = 8'h23;
  localparam logic [7:0] EX_BUSY        = 8'h24;
  localparam logic [7:0] FC_EXC_BIT     = 8'h80;
  // ************************************************************
  // Request limits and special addresses
  // ************************************************************
  localparam logic [7:0]  QTY_MIN        = 8'h01;
  localparam logic [7:0]  QTY_MAX        = 8'h10;
  localparam logic [15:0] BCAST_LAST     = 16'h0002;
  localparam logic [7:0]  SLAVE_BCAST    = 8'h00;
  localparam logic [15:0] ENTER_EEPROM   = 16'h0900;
  localparam logic [15:0] ENTER_RAM      = 16'h0910;
  localparam logic [7:0]  TEST_MODE_CODE = 8'h43;
  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_REQ0    = 8'h04;
  localparam logic [7:0] OFS_REQ1    = 8'h08;
  localparam logic [7:0] OFS_CMD     = 8'h0c;
  localparam logic [7:0] OFS_RESULT  = 8'h10;
  localparam logic [7:0] OFS_ERRDET  = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CMD_GO_BIT     = 0;
  localparam int CMD_FRST_BIT   = 1;
  localparam int CMD_LBPASS_BIT = 2;
  localparam int CMD_LBFAIL_BIT = 3;
  localparam int CMD_LBDONE_BIT = 4;
  localparam int ERR_CRC_BIT    = 0;
  localparam int ERR_LEN_BIT    = 1;
  localparam int ERR_PAR_BIT    = 3;
  localparam int ERR_OVR_BIT    = 4;
  localparam int ERR_FRM_BIT    = 5;
  localparam int ERR_TMO_BIT    = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // ************************************************************
  // Bus response codes and timing
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int GAP_BITS = 24;
endpackage : mbchk_pkg

// >>> rtl/mbchk_top.sv
// Request checker of the serial slave, with AXI4-Lite register access
// Summary of operation
// R1 - Function codes other than read, loopback, write-multiple get exception 01H.
// R2 - Unmapped register address gets the invalid-register exception.
// R3 - Broadcast write must start at one of the three broadcast registers.
// R4 - Register count below one or above sixteen gets invalid-quantity exception.
// R5 - Write byte count must equal twice register count, else invalid-quantity.
// R6 - Out-of-bound or invalid written value gets exception 21H.
// R7 - Parameter or commit writes while running get the write-mode exception.
// R8 - With memory alarm, only a fixed parameter set may be written.
// R9 - Writes to read-only registers get the write-mode exception.
// R10 - Parameter or commit writes during undervoltage get exception 23H.
// R11 - Parameter write during internal parameter processing gets exception 24H.
// R12 - Address zero: every slave executes the write, none replies.
// R13 - Overrun, framing, parity or checksum errors: discard, no reply.
// R14 - Foreign slave address: ignore, no reply.
// R15 - Gap over 24 bit times within a frame: discard, no reply.
// R16 - Inconsistent data length: discard silently.
// R17 - The master should time out and resend the same command.
// R18 - Test mode code 67 at power-up runs the loopback self-test.
// R19 - Error-free self-test shows a pass indication.
// R20 - Self-test failure raises comm alarm, fault contact, drops ready.
// R21 - Comm error detail flags latch until a fault reset, even running.
// R22 - Commit registers are write-only; reading them gives invalid-register.
// R23 - Exception reply echoes address, sets function MSB, carries code.
// R24 - Checks run: integrity and address, function, register, quantity, write.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module mbchk_top #(
  parameter int GAP_LIMIT = mbchk_pkg::GAP_BITS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        drive_running,
  input  wire logic        nvm_defect_alarm,
  input  wire logic        main_undervoltage_alarm,
  input  wire logic        param_busy,
  input  wire logic [7:0]  input_s7_function_select,
  output logic             reply_valid,
  output logic             reply_silent,
  output logic             execute,
  output logic [7:0]       reply_func,
  output logic [7:0]       reply_code,
  output logic [7:0]       reply_addr,
  output logic             test_mode,
  output logic             selftest_pass,
  output logic             comm_error_alarm,
  output logic             fault_contact,
  output logic             operation_ready
);
  if (GAP_LIMIT < 1 || GAP_LIMIT > 255) begin : g_gap_chk
    $error("GAP_LIMIT out of range");
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]  own_addr_r;      // Configured slave address
  logic [31:0] req0_r;          // [7:0] slave, [15:8] func, [31:16] start address
  logic [31:0] req1_r;          // [7:0] qty, [15:8] byte count, [16] value out of range,
                                // [17] address mapped, [18] read-only, [19] parameter,
                                // [20] nvm-allowed, [21..26] frame error flags,
                                // [31:24] longest gap in bit times
  logic [6:0]  errdet_r;
  logic [7:0]  res_code_r;
  logic        res_silent_r;
  logic        res_exec_r;
  logic        go_r;
  logic        awpend_r;
  logic        wpend_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [7:0]  s7_meta_r;
  logic [7:0]  s7_sync_r;
  logic [1:0]  pwr_seen_r;
  logic        lb_done_r;

  // ************************************************************
  // Request decode
  // ************************************************************
  wire [7:0]  req_slave  = req0_r[7:0];
  wire [7:0]  req_func   = req0_r[15:8];
  wire [15:0] req_start  = req0_r[31:16];
  wire [7:0]  req_qty    = req1_r[7:0];
  wire [7:0]  req_bytes  = req1_r[15:8];
  wire        val_bad    = req1_r[16];
  wire        mapped     = req1_r[17];
  wire        read_only  = req1_r[18];
  wire        is_param   = req1_r[19];
  wire        nvm_ok     = req1_r[20];
  wire [5:0]  frame_err  = req1_r[26:21];
  wire [7:0]  max_gap    = req1_r[31:24];
  wire        is_bcast   = (req_slave == mbchk_pkg::SLAVE_BCAST);
  wire        is_write   = (req_func == mbchk_pkg::FC_WRITE_MULTI);
  wire        is_read    = (req_func == mbchk_pkg::FC_READ);
  wire        is_enter   = (req_start == mbchk_pkg::ENTER_EEPROM)
                         || (req_start == mbchk_pkg::ENTER_RAM);
  wire        gap_bad    = (max_gap > 8'(GAP_LIMIT));
  wire [8:0]  twice_qty  = {req_qty, 1'b0};

  // Silent discard: integrity, gap, length, foreign address
  wire integ_bad = frame_err[0] || frame_err[2] || frame_err[3] || frame_err[4]; // R13
  wire len_bad   = frame_err[1];                                                 // R16
  wire addr_bad  = !is_bcast && (req_slave != own_addr_r);                       // R14
  wire discard   = integ_bad || gap_bad || len_bad || addr_bad;                  // R15

  // Priority chain of exception codes
  logic [7:0] code_c;
  always_comb begin
    code_c = mbchk_pkg::EX_NONE;                                          // R24
    if (!is_read && !is_write && req_func != mbchk_pkg::FC_LOOPBACK)
      code_c = mbchk_pkg::EX_FUNC;                                        // R1
    else if (req_func == mbchk_pkg::FC_LOOPBACK)
      code_c = mbchk_pkg::EX_NONE;
    else if (is_bcast && req_start > mbchk_pkg::BCAST_LAST)
      code_c = mbchk_pkg::EX_REG;                                         // R3
    else if (!mapped || (is_read && is_enter))
      code_c = mbchk_pkg::EX_REG;                                         // R2 R22
    else if (req_qty < mbchk_pkg::QTY_MIN || req_qty > mbchk_pkg::QTY_MAX)
      code_c = mbchk_pkg::EX_QTY;                                         // R4
    else if (is_write && {1'b0, req_bytes} != twice_qty)
      code_c = mbchk_pkg::EX_QTY;                                         // R5
    else if (is_write && read_only)
      code_c = mbchk_pkg::EX_WMODE;                                       // R9
    else if (is_write && (is_param || is_enter) && drive_running)
      code_c = mbchk_pkg::EX_WMODE;                                       // R7
    else if (is_write && is_param && nvm_defect_alarm && !nvm_ok)
      code_c = mbchk_pkg::EX_WMODE;                                       // R8
    else if (is_write && (is_param || is_enter) && main_undervoltage_alarm)
      code_c = mbchk_pkg::EX_UV;                                          // R10
    else if (is_write && is_param && param_busy)
      code_c = mbchk_pkg::EX_BUSY;                                        // R11
    else if (is_write && val_bad)
      code_c = mbchk_pkg::EX_DATA;                                        // R6
  end

  // Broadcast writes run without reply; read broadcasts are not executed
  wire silent_c = discard || is_bcast;                                    // R12
  wire exec_c   = !discard && (code_c == mbchk_pkg::EX_NONE)
                  && (!is_bcast || is_write);                             // R12

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;
  wire        wr_fire  = awpend_r && wpend_r && !s_axi_bvalid;
  wire        ar_take  = s_axi_arvalid && s_axi_arready;
  wire [31:0] wmask    = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire        wr_ctrl  = wr_fire && awaddr_r == mbchk_pkg::OFS_CTRL;
  wire        wr_req0  = wr_fire && awaddr_r == mbchk_pkg::OFS_REQ0;
  wire        wr_req1  = wr_fire && awaddr_r == mbchk_pkg::OFS_REQ1;
  wire        wr_cmd   = wr_fire && awaddr_r == mbchk_pkg::OFS_CMD;
  wire        wr_map   = wr_ctrl || wr_req0 || wr_req1 || wr_cmd;
  wire        cmd_go   = wr_cmd && wdata_r[mbchk_pkg::CMD_GO_BIT];
  wire        cmd_frst = wr_cmd && wdata_r[mbchk_pkg::CMD_FRST_BIT];
  wire        lb_pass  = wr_cmd && wdata_r[mbchk_pkg::CMD_LBPASS_BIT] && test_mode;
  wire        lb_fail  = wr_cmd && wdata_r[mbchk_pkg::CMD_LBFAIL_BIT] && test_mode;

  // Read multiplexer
  logic [31:0] rd_c;
  logic        rd_ok_c;
  always_comb begin
    rd_ok_c = 1'b1;
    unique case (s_axi_araddr)
      mbchk_pkg::OFS_CTRL:   rd_c = {24'h0, own_addr_r};
      mbchk_pkg::OFS_REQ0:   rd_c = req0_r;
      mbchk_pkg::OFS_REQ1:   rd_c = req1_r;
      mbchk_pkg::OFS_CMD:    rd_c = {27'h0, lb_done_r, 3'h0, go_r};
      mbchk_pkg::OFS_RESULT: rd_c = {22'h0, res_exec_r, res_silent_r, res_code_r};
      mbchk_pkg::OFS_ERRDET: rd_c = {25'h0, errdet_r};
      mbchk_pkg::OFS_STATUS: rd_c = {26'h0, operation_ready, fault_contact,
                                     comm_error_alarm, selftest_pass, test_mode,
                                     reply_valid};
      default: begin
        rd_c    = 32'h0;
        rd_ok_c = 1'b0;
      end
    endcase
  end

  // Write channel handshake and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awpend_r      <= 1'b0;
      wpend_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mbchk_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !awpend_r && !aw_take;
      s_axi_wready  <= !wpend_r && !w_take;
      if (aw_take) begin
        awpend_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wpend_r <= 1'b1;
        wdata_r <= s_axi_wdata & wmask;
      end
      if (wr_fire) begin
        awpend_r     <= 1'b0;
        wpend_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? mbchk_pkg::RESP_OKAY : mbchk_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= mbchk_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_c;
        s_axi_rresp  <= rd_ok_c ? mbchk_pkg::RESP_OKAY : mbchk_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Request registers and checking
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_addr_r <= mbchk_pkg::CTRL_RST[7:0];
      req0_r     <= 32'h0;
      req1_r     <= 32'h0;
      go_r       <= 1'b0;
    end else begin
      if (wr_ctrl) own_addr_r <= wdata_r[7:0];
      if (wr_req0) req0_r <= wdata_r;
      if (wr_req1) req1_r <= wdata_r;
      go_r <= cmd_go;
    end
  end

  // Result of one check: code, silence and execution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_code_r   <= mbchk_pkg::EX_NONE;
      res_silent_r <= 1'b0;
      res_exec_r   <= 1'b0;
      reply_valid  <= 1'b0;
      reply_silent <= 1'b0;
      execute      <= 1'b0;
      reply_func   <= 8'h00;
      reply_code   <= 8'h00;
      reply_addr   <= 8'h00;
    end else begin
      reply_valid  <= go_r;
      reply_silent <= go_r && silent_c;
      execute      <= go_r && exec_c;
      if (go_r) begin
        res_code_r   <= discard ? mbchk_pkg::EX_NONE : code_c;
        res_silent_r <= silent_c;
        res_exec_r   <= exec_c;
        reply_addr   <= req_slave;                                                  // R23
        reply_code   <= discard ? mbchk_pkg::EX_NONE : code_c;                      // R23
        reply_func   <= (code_c != mbchk_pkg::EX_NONE) ? (req_func | mbchk_pkg::FC_EXC_BIT)
                                                       : req_func;                  // R23
      end
    end
  end

  // Sticky error details; a new error wins over a fault reset
  wire [6:0] err_new = go_r ? {frame_err[5:2], 1'b0, frame_err[1:0]} : 7'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      errdet_r <= 7'h00;
    end else begin
      errdet_r <= (cmd_frst ? 7'h00 : errdet_r) | err_new;                         // R21
    end
  end

  // ************************************************************
  // Loopback self-test
  // ************************************************************
  wire s7_test = (s7_sync_r == mbchk_pkg::TEST_MODE_CODE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s7_meta_r        <= 8'h00;
      s7_sync_r        <= 8'h00;
      pwr_seen_r       <= 2'b00;
      test_mode        <= 1'b0;
      lb_done_r        <= 1'b0;
      selftest_pass    <= 1'b0;
      comm_error_alarm <= 1'b0;
      fault_contact    <= 1'b0;
      operation_ready  <= 1'b0;
    end else begin
      s7_meta_r  <= input_s7_function_select;
      s7_sync_r  <= s7_meta_r;
      pwr_seen_r <= {pwr_seen_r[0], 1'b1}; // Wait until the synced code is valid
      if (pwr_seen_r[1] && !lb_done_r && !test_mode) begin
        test_mode <= s7_test;                                                       // R18
        lb_done_r <= !s7_test;
        operation_ready <= !s7_test;
      end
      if (lb_pass) begin
        selftest_pass   <= 1'b1;                                                    // R19
        lb_done_r       <= 1'b1;
        test_mode       <= 1'b0;
        operation_ready <= 1'b1;
      end else if (lb_fail) begin
        comm_error_alarm <= 1'b1;                                                   // R20
        fault_contact    <= 1'b1;                                                   // R20
        operation_ready  <= 1'b0;                                                   // R20
        lb_done_r        <= 1'b1;
        test_mode        <= 1'b0;
      end
    end
  end
endmodule : mbchk_top

// >>> sim/mbchk_master_model.sv
// Serial master model: response timer that flags a resend when no reply comes back
`timescale 1ns/100ps
module mbchk_master_model #(
  parameter int TMO = 16
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic sent,
  input  wire logic reply_valid,
  input  wire logic reply_silent,
  output logic      resend_due
);
  int cnt_r;
  // Timer starts on each request and stops on a sent reply
  always_ff @(posedge aclk) begin
    if (!aresetn || sent) begin
      cnt_r      <= aresetn ? TMO : 0;
      resend_due <= 1'b0;
    end else if (reply_valid && !reply_silent) begin
      cnt_r <= 0;
    end else if (cnt_r > 0) begin
      cnt_r      <= cnt_r - 1;
      resend_due <= (cnt_r == 1);
    end
  end
endmodule : mbchk_master_model

// >>> sim/mbchk_sva.sv
// Checker of reply and status relations at the top-level ports
`timescale 1ns/100ps
module mbchk_sva #(
  parameter int GAP_LIMIT = 24
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        reply_valid,
  input wire logic        reply_silent,
  input wire logic        execute,
  input wire logic [7:0]  reply_func,
  input wire logic [7:0]  reply_code,
  input wire logic [7:0]  reply_addr,
  input wire logic        test_mode,
  input wire logic        selftest_pass,
  input wire logic        comm_error_alarm,
  input wire logic        fault_contact,
  input wire logic        operation_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ************************************************************
  // Reply relations
  // ************************************************************
  a_exc_func_msb: assert property (reply_valid && reply_code != 8'h00 |-> reply_func[7])
    else $error("exception reply without function flag");
  a_exec_no_exc: assert property (reply_valid && execute |-> reply_code == mbchk_pkg::EX_NONE)
    else $error("request executed despite exception");
  a_bcast_silent: assert property (reply_valid && reply_addr == 8'h00 |-> reply_silent)
    else $error("reply sent for broadcast");
  a_flags_paired: assert property (reply_silent || execute |-> reply_valid)
    else $error("silent or execute without reply_valid");
  a_reply_pulse: assert property (reply_valid |=> !reply_valid)
    else $error("reply_valid longer than one cycle");
  a_code_hold: assert property (reply_valid |=> $stable(reply_code) && $stable(reply_addr))
    else $error("reply fields changed without a check");
  // ************************************************************
  // Bus and self-test relations
  // ************************************************************
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  a_fail_outputs: assert property (comm_error_alarm |-> fault_contact && !operation_ready)
    else $error("alarm without fault contact");
  a_pass_clean: assert property (selftest_pass |-> !test_mode && !comm_error_alarm)
    else $error("pass shown with alarm");
  a_test_busy: assert property (test_mode |-> !operation_ready)
    else $error("ready during test mode");
endmodule : mbchk_sva
bind mbchk_top mbchk_sva #(.GAP_LIMIT(GAP_LIMIT)) i_mbchk_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .reply_valid(reply_valid),
  .reply_silent(reply_silent), .execute(execute), .reply_func(reply_func),
  .reply_code(reply_code), .reply_addr(reply_addr), .test_mode(test_mode),
  .selftest_pass(selftest_pass), .comm_error_alarm(comm_error_alarm),
  .fault_contact(fault_contact), .operation_ready(operation_ready));

// >>> sim/mbchk_tb_top.sv
// Testbench top: request checks and self-test driven over AXI4-Lite
`timescale 1ns/100ps
module mbchk_tb_top;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, sent, due;
  logic        awr, wr, bv, arr, rv, rvl, rsl, ex, tm, sp, cea, fc, ordy;
  logic [7:0]  aw, ar, sel, rf, rc, ra;
  logic [31:0] wd, rd, v;
  logic [1:0]  br, rr, rsp;
  logic [3:0]  cnd;
  int          err_total, num_checks;
  localparam logic [31:0] RD1 = 32'h0002_0001;
  localparam logic [31:0] WP  = 32'h000a_0201;
  // Device under test and master model
  mbchk_top #(.GAP_LIMIT(24)) i_mbchk_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .drive_running(cnd[3]), .nvm_defect_alarm(cnd[2]), .main_undervoltage_alarm(cnd[1]),
    .param_busy(cnd[0]), .input_s7_function_select(sel), .reply_valid(rvl),
    .reply_silent(rsl), .execute(ex), .reply_func(rf), .reply_code(rc), .reply_addr(ra),
    .test_mode(tm), .selftest_pass(sp), .comm_error_alarm(cea), .fault_contact(fc),
    .operation_ready(ordy));
  mbchk_master_model #(.TMO(16)) i_mbchk_master_model (.aclk(aclk), .aresetn(aresetn),
    .sent(sent), .reply_valid(rvl), .reply_silent(rsl), .resend_due(due));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    rsp = br;
    bry <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rd;
    rsp = rr;
    rry <= 1'b0;
  endtask : axr
  // Loads one request, starts it and checks reply, result and master timer
  task automatic chk(input logic [31:0] r0, input logic [31:0] r1, input logic [3:0] c,
                     input logic [7:0] e, input logic s, input logic x);
    int n;
    cnd <= c;
    sent <= 1'b1;
    axw(8'h04, r0);
    axw(8'h08, r1);
    sent <= 1'b0;
    axw(8'h0c, 32'h0000_0001);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvl && n < 20);
    cmp({rvl, rsl, ex, rc}, {1'b1, s, x, e}, "reply");
    if (!s) cmp({ra, rf}, {r0[7:0], r0[15:8] | ((e != 8'h00) ? 8'h80 : 8'h00)}, "echo");
    axr(8'h10);
    cmp(v[9:0], {x, s, e}, "result");
    repeat (20) @(posedge aclk);
    cmp(due, s, "resend");
    cnd <= 4'h0;
  endtask : chk
  task automatic rst(input logic [7:0] s);
    @(posedge aclk);
    sel <= s;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask : rst
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // ************************************************************
  // Clock, watchdog and test sequence
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out();
  end
  initial begin
    {aresetn, awv, wv, bry, arv, rry, sent} = '0;
    {aw, ar, wd, cnd, sel} = '0;
    err_total = 0;
    num_checks = 0;
    rst(8'h00);
    cmp(ordy, 1'b1, "ready");
    axr(8'h00);
    cmp(v, mbchk_pkg::CTRL_RST, "ctrl reset");
    axr(8'h1c);
    cmp(v, 32'h0, "unmapped data");
    cmp(rsp, mbchk_pkg::RESP_SLVERR, "unmapped read");
    axw(8'h1c, 32'h0000_00ff);
    cmp(rsp, mbchk_pkg::RESP_SLVERR, "unmapped write");
    $display("test registers done");
    chk(32'h0010_0301, RD1, 4'h0, 8'h00, 0, 1);
    chk(32'h0000_0801, RD1, 4'h0, 8'h00, 0, 1);
    chk(32'h0010_0501, 32'h0, 4'h0, 8'h01, 0, 0);
    chk(32'h0010_0301, 32'h0, 4'h0, 8'h02, 0, 0);
    chk(32'h0900_0301, RD1, 4'h0, 8'h02, 0, 0);
    chk(32'h0005_1000, 32'h0002_0201, 4'h0, 8'h02, 1, 0);
    chk(32'h0001_1000, 32'h0002_0201, 4'h0, 8'h00, 1, 1);
    chk(32'h0010_0301, 32'h0002_0000, 4'h0, 8'h03, 0, 0);
    chk(32'h0010_0301, 32'h0002_0011, 4'h0, 8'h03, 0, 0);
    chk(32'h0010_0301, 32'h0002_0010, 4'h0, 8'h00, 0, 1);
    chk(32'h0010_1001, 32'h0002_0302, 4'h0, 8'h03, 0, 0);
    chk(32'h0010_1001, 32'h0002_0402, 4'h0, 8'h00, 0, 1);
    chk(32'h0010_1001, 32'h0003_0201, 4'h0, 8'h21, 0, 0);
    chk(32'h0010_1001, 32'h0006_0201, 4'h0, 8'h22, 0, 0);
    chk(32'h0010_1001, WP, 4'h8, 8'h22, 0, 0);
    chk(32'h0900_1001, 32'h0002_0201, 4'h8, 8'h22, 0, 0);
    chk(32'h0010_1001, WP, 4'h4, 8'h22, 0, 0);
    chk(32'h0010_1001, 32'h001a_0201, 4'h4, 8'h00, 0, 1);
    chk(32'h0010_1001, WP, 4'h2, 8'h23, 0, 0);
    chk(32'h0910_1001, 32'h0002_0201, 4'h2, 8'h23, 0, 0);
    chk(32'h0010_1001, WP, 4'h1, 8'h24, 0, 0);
    chk(32'h0010_0301, 32'h0022_0001, 4'h0, 8'h00, 1, 0);
    chk(32'h0010_0301, 32'h0082_0001, 4'h0, 8'h00, 1, 0);
    chk(32'h0010_0301, 32'h0202_0001, 4'h0, 8'h00, 1, 0);
    chk(32'h0010_0302, RD1, 4'h0, 8'h00, 1, 0);
    chk(32'h0010_0301, 32'h1802_0001, 4'h0, 8'h00, 0, 1);
    chk(32'h0010_0301, 32'h1902_0001, 4'h0, 8'h00, 1, 0);
    chk(32'h0010_0301, 32'h0442_0001, 4'h0, 8'h00, 1, 0);
    $display("test requests done");
    axr(8'h14);
    cmp(v, 32'h0000_007b, "error detail");
    axw(8'h0c, 32'h0000_0002);
    axr(8'h14);
    cmp(v, 32'h0, "error detail cleared");
    $display("test error detail done");
    rst(8'h43);
    cmp({tm, ordy}, 2'b10, "test mode");
    axw(8'h0c, 32'h0000_0008);
    repeat (3) @(posedge aclk);
    cmp({cea, fc, ordy, sp}, 4'b1100, "self-test fail");
    rst(8'h43);
    axw(8'h0c, 32'h0000_0004);
    repeat (3) @(posedge aclk);
    cmp({sp, cea, fc}, 3'b100, "self-test pass");
    $display("test self-test done");
    close_out();
  end
endmodule : mbchk_tb_top
